// file: hdl/lsh_pkg.sv
// shared types and constants for the link status transaction handler
package lsh_pkg;

    // ==========================================================
    // packet kinds handed over by the device core
    // ==========================================================
    localparam int KIND_W = 3;
    typedef enum logic [KIND_W-1:0] {
        KIND_NP_REQ   = 3'h0,
        KIND_POSTED   = 3'h1,
        KIND_CPL      = 3'h2,
        KIND_PM_OFF   = 3'h3,
        KIND_VDM_T0   = 3'h4,
        KIND_VDM_T1   = 3'h5,
        KIND_SLOT_PWR = 3'h6
    } lsh_kind_type;

    // ==========================================================
    // field widths and codes
    // ==========================================================
    localparam int TAG_W       = 8;
    localparam int OUTS_N      = 4;
    localparam int OUTS_IDX_W  = 2;
    localparam int SCALE_W     = 2;
    localparam int VALUE_W     = 8;
    localparam int DATA_W      = SCALE_W + VALUE_W;
    localparam int CPL_ST_W    = 3;
    localparam logic [CPL_ST_W-1:0] CPL_ST_UR = 3'h1;
    localparam logic [OUTS_N-1:0]   OUTS_RST  = 4'h0;

    // ==========================================================
    // carriers
    // ==========================================================
    typedef struct packed {
        logic               valid;
        lsh_kind_type       kind;
        logic [TAG_W-1:0]   tag;
        logic [DATA_W-1:0]  data;
    } lsh_pkt_type;

    typedef struct packed {
        logic                 valid;
        logic [TAG_W-1:0]     tag;
        logic [CPL_ST_W-1:0]  status;
    } lsh_cpl_type;

    typedef struct packed {
        logic               valid;
        logic               acked;
    } lsh_rx_type;

    // ==========================================================
    // link view states
    // ==========================================================
    typedef enum logic [1:0] {
        LINK_DOWN = 2'b01,
        LINK_UP   = 2'b10
    } lsh_link_type;

    localparam lsh_pkt_type PKT_RST = '{valid: 1'b0, kind: KIND_NP_REQ,
                                        tag: 8'h00, data: 10'h000};
    localparam lsh_cpl_type CPL_RST = '{valid: 1'b0, tag: 8'h00,
                                        status: 3'h0};

    // ==========================================================
    // whole state of the handler
    // ==========================================================
    typedef struct packed {
        lsh_link_type       link;
        lsh_pkt_type        tx;
        logic               core_ready;
        logic [OUTS_N-1:0]  outstanding;
        lsh_cpl_type        cpl;
        logic               bridge_ur_err;
        logic               pm_ack;
        logic               spl_pending;
        logic               rx_accept;
        logic               credit_return;
        logic               down_seen;
        logic               port_reset;
        logic               hot_reset;
    } lsh_state_type;

endpackage

// file: hdl/lsh_txn_handler.sv
// transaction layer reaction to link active and inactive status
`timescale 1ns/1ps

module lsh_txn_handler (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          link_active_status,
    input  wire logic                          port_is_downstream,
    input  wire logic                          port_is_root,
    input  wire logic                          root_report_en,
    input  wire logic                          slot_cap_init,
    input  wire logic [lsh_pkg::SCALE_W-1:0]   slot_pwr_scale,
    input  wire logic [lsh_pkg::VALUE_W-1:0]   slot_pwr_value,
    input  wire logic                          status_clear,
    input  wire lsh_pkg::lsh_pkt_type          core_req,
    output logic                               core_req_ready,
    output lsh_pkg::lsh_pkt_type               tx_pkt,
    input  wire logic                          tx_ready,
    input  wire lsh_pkg::lsh_cpl_type          rx_cpl,
    input  wire lsh_pkg::lsh_rx_type           rx_pkt,
    output logic                               rx_accept,
    output logic                               credit_return,
    output lsh_pkg::lsh_cpl_type               core_cpl,
    output logic [lsh_pkg::OUTS_N-1:0]         outstanding,
    output logic                               bridge_ur_err,
    output logic                               pm_ack,
    output logic                               link_down_seen,
    output logic                               port_reset,
    output logic                               downstream_hot_reset
);

    // ==========================================================
    // state
    // ==========================================================
    lsh_pkg::lsh_state_type state_reg;
    lsh_pkg::lsh_state_type state_next;

    logic link_up;
    logic link_rise;
    logic link_fall;
    logic report_en;
    logic take_req;

    // level from the link layer on this clock, no synchroniser
    // level status
    assign link_up   = link_active_status;
    assign link_rise = link_up && (state_reg.link == lsh_pkg::LINK_DOWN);
    assign link_fall = !link_up && (state_reg.link == lsh_pkg::LINK_UP);
    assign report_en = !port_is_root || root_report_en;
    assign take_req  = core_req.valid && state_reg.core_ready;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        state_next = state_reg;
        state_next.link = link_up ? lsh_pkg::LINK_UP : lsh_pkg::LINK_DOWN;
        state_next.cpl.valid = 1'b0;
        state_next.bridge_ur_err = 1'b0;
        state_next.pm_ack = 1'b0;
        state_next.port_reset = 1'b0;
        state_next.hot_reset = 1'b0;

        state_next.rx_accept = rx_pkt.valid && (link_up || rx_pkt.acked);
        state_next.credit_return = state_next.rx_accept;

        // completions returning from the link retire their entry
        if (rx_cpl.valid && link_up)
        begin
            state_next.outstanding[rx_cpl.tag[lsh_pkg::OUTS_IDX_W-1:0]] = 1'b0;
        end

        // transmit stage drains only over a live link
        if (state_reg.tx.valid && tx_ready && link_up)
        begin
            state_next.tx.valid = 1'b0;
        end

        if (take_req)
        begin
            if (link_up)
            begin
                state_next.tx = core_req;
                if (core_req.kind == lsh_pkg::KIND_NP_REQ)
                begin
                    state_next.outstanding[core_req.tag[lsh_pkg::OUTS_IDX_W-1:0]] = 1'b1;
                end
            end
            else if (port_is_downstream)
            begin
                unique case (core_req.kind)
                    lsh_pkg::KIND_NP_REQ:
                    begin
                        state_next.cpl.valid = 1'b1;
                        state_next.cpl.tag = core_req.tag;
                        state_next.cpl.status = lsh_pkg::CPL_ST_UR;
                        state_next.bridge_ur_err = report_en;
                    end
                    lsh_pkg::KIND_POSTED:
                    begin
                        state_next.bridge_ur_err = report_en;
                    end
                    lsh_pkg::KIND_PM_OFF:
                    begin
                        state_next.pm_ack = 1'b1;
                    end
                    // type 0 unsupported like any posted
                    lsh_pkg::KIND_VDM_T0:
                    begin
                        state_next.bridge_ur_err = report_en;
                    end
                    default:
                    begin
                        state_next.bridge_ur_err = 1'b0;
                    end
                endcase
            end
        end

        if (link_fall)
        begin
            state_next.tx.valid = 1'b0;
            state_next.spl_pending = 1'b0;
            state_next.down_seen = 1'b1;
            if (port_is_downstream)
            begin
                state_next.outstanding = lsh_pkg::OUTS_RST;
            end
            else
            begin
                state_next.port_reset = 1'b1;
                state_next.outstanding = lsh_pkg::OUTS_RST;
                state_next.hot_reset = 1'b1;
            end
        end
        else if (status_clear)
        begin
            state_next.down_seen = 1'b0;
        end

        if (link_rise && port_is_downstream && slot_cap_init)
        begin
            state_next.spl_pending = 1'b1;
        end

        // slot power message takes the stage ahead of the core
        if (state_reg.spl_pending && !state_next.tx.valid && link_up)
        begin
            state_next.tx.valid = 1'b1;
            state_next.tx.kind = lsh_pkg::KIND_SLOT_PWR;
            state_next.tx.tag = '0;
            state_next.tx.data = {slot_pwr_scale, slot_pwr_value};
            state_next.spl_pending = 1'b0;
        end

        // while down every request is disposed of at once
        state_next.core_ready = !state_next.spl_pending
                                && (!link_up || !state_next.tx.valid);
        if (link_rise && port_is_downstream && slot_cap_init)
        begin
            state_next.core_ready = 1'b0;
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg.link <= lsh_pkg::LINK_DOWN;
            state_reg.tx <= lsh_pkg::PKT_RST;
            state_reg.core_ready <= 1'b0;
            state_reg.outstanding <= lsh_pkg::OUTS_RST;
            state_reg.cpl <= lsh_pkg::CPL_RST;
            state_reg.bridge_ur_err <= 1'b0;
            state_reg.pm_ack <= 1'b0;
            state_reg.spl_pending <= 1'b0;
            state_reg.rx_accept <= 1'b0;
            state_reg.credit_return <= 1'b0;
            state_reg.down_seen <= 1'b0;
            state_reg.port_reset <= 1'b0;
            state_reg.hot_reset <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign core_req_ready       = state_reg.core_ready;
    assign tx_pkt               = state_reg.tx;
    assign rx_accept            = state_reg.rx_accept;
    assign credit_return        = state_reg.credit_return;
    assign core_cpl             = state_reg.cpl;
    assign outstanding          = state_reg.outstanding;
    assign bridge_ur_err        = state_reg.bridge_ur_err;
    assign pm_ack               = state_reg.pm_ack;
    assign link_down_seen       = state_reg.down_seen;
    assign port_reset           = state_reg.port_reset;
    assign downstream_hot_reset = state_reg.hot_reset;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    rx_refuse_a: assert property (
        (rx_pkt.valid && !link_up && !rx_pkt.acked) |=> !rx_accept && !credit_return)
        else $error("unacked packet taken while link down");

    outs_clear_a: assert property (
        (link_fall && port_is_downstream) |=> outstanding == lsh_pkg::OUTS_RST)
        else $error("outstanding state kept after link loss");

    np_ur_cpl_a: assert property (
        (take_req && !link_up && port_is_downstream
         && core_req.kind == lsh_pkg::KIND_NP_REQ)
        |=> core_cpl.valid && core_cpl.status == lsh_pkg::CPL_ST_UR
            && core_cpl.tag == $past(core_req.tag))
        else $error("no unsupported completion for non-posted");

    pm_ack_a: assert property (
        (take_req && !link_up && port_is_downstream
         && core_req.kind == lsh_pkg::KIND_PM_OFF) |=> pm_ack)
        else $error("turn-off request not acknowledged");

    posted_err_a: assert property (
        (take_req && !link_up && port_is_downstream && !port_is_root
         && core_req.kind == lsh_pkg::KIND_POSTED) |=> bridge_ur_err)
        else $error("discarded posted not reported");

    no_tx_down_a: assert property (
        (!link_up && take_req) |=> !tx_pkt.valid)
        else $error("packet sent while link down");

    hot_pulse_a: assert property (
        downstream_hot_reset |=> !downstream_hot_reset)
        else $error("hot reset held");

    up_reset_a: assert property (
        (link_fall && !port_is_downstream) |=> port_reset && downstream_hot_reset)
        else $error("upstream loss did not reset");

    rx_accept_a: assert property (
        (rx_pkt.valid && link_up) |=> rx_accept && credit_return)
        else $error("packet refused while link active");

    // a core request taken on the very rise edge can delay the message
    spl_send_a: assert property (
        (link_rise && port_is_downstream && slot_cap_init && link_up) ##1 link_up
        |-> ##[0:2] (tx_pkt.valid && tx_pkt.kind == lsh_pkg::KIND_SLOT_PWR))
        else $error("slot power message not sent");

    spl_skip_a: assert property (
        (link_rise && !slot_cap_init && !state_reg.spl_pending) |=> !state_reg.spl_pending)
        else $error("slot power queued without capabilities");

    // pulses are judged one cycle after the edge that caused them
    inflight_quiet_a: assert property (
        (link_fall && !take_req) |=> !bridge_ur_err && !core_cpl.valid)
        else $error("in-flight packet reported on link loss");

    posted_drop_a: assert property (
        (take_req && !link_up && port_is_downstream
         && core_req.kind == lsh_pkg::KIND_POSTED) |=> !tx_pkt.valid && !core_cpl.valid)
        else $error("posted request not discarded");

    vdm_silent_a: assert property (
        (take_req && !link_up && core_req.kind == lsh_pkg::KIND_VDM_T1)
        |=> !bridge_ur_err && !core_cpl.valid)
        else $error("vendor type 1 message not dropped silently");

    cpl_drop_a: assert property (
        (take_req && !link_up && core_req.kind == lsh_pkg::KIND_CPL)
        |=> !bridge_ur_err && !core_cpl.valid && !tx_pkt.valid)
        else $error("completion not dropped while link down");

    down_seen_a: assert property (
        link_fall |=> link_down_seen)
        else $error("link loss not recorded");

    seen_stable_a: assert property (
        (!link_fall && !status_clear) |=> $stable(link_down_seen))
        else $error("link loss status changed without cause");

    fall_flush_a: assert property (
        link_fall |=> !tx_pkt.valid)
        else $error("packet kept after link loss");

    up_outs_a: assert property (
        (link_fall && !port_is_downstream) |=> outstanding == lsh_pkg::OUTS_RST)
        else $error("upstream state kept after link loss");

    hot_down_a: assert property (
        (link_fall && port_is_downstream) |=> !downstream_hot_reset && !port_reset)
        else $error("hot reset on a downstream port");

    cov_np_ur_c: cover property (core_cpl.valid);
    cov_spl_c: cover property (tx_pkt.valid && tx_pkt.kind == lsh_pkg::KIND_SLOT_PWR);
    cov_hot_c: cover property (downstream_hot_reset);
    cov_refuse_c: cover property (rx_pkt.valid && !link_up && !rx_pkt.acked);
    cov_pm_c: cover property (pm_ack);

endmodule

// file: test/lsh_link_model.sv
// link layer stand-in: status level and transmit acceptance with stall
`timescale 1ns/1ps

module lsh_link_model #(
    parameter int DLY = 2
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  link_cmd,
    input  wire lsh_pkg::lsh_pkt_type  tx_pkt,
    output logic                       link_active_status,
    output logic                       tx_ready,
    output lsh_pkg::lsh_pkt_type       last_pkt,
    output logic [7:0]                 n_taken
);
    logic [3:0] wait_reg;

    // ==========================================================
    // status level and transmit side
    // ==========================================================
    // status level, port clock
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_active_status <= 1'b0;
            tx_ready           <= 1'b0;
            wait_reg           <= 4'h0;
            n_taken            <= 8'h00;
            last_pkt           <= lsh_pkg::PKT_RST;
        end
        else
        begin
            link_active_status <= link_cmd;
            if (tx_ready && tx_pkt.valid)
            begin
                last_pkt <= tx_pkt;
                n_taken  <= n_taken + 8'h01;
                tx_ready <= 1'b0;
                wait_reg <= 4'h0;
            end
            // no stale ready once the packet is withdrawn
            else if (!tx_pkt.valid || !link_active_status)
            begin
                tx_ready <= 1'b0;
                wait_reg <= 4'h0;
            end
            else if (wait_reg == 4'(DLY))
                tx_ready <= 1'b1;
            else
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

// file: test/tb_top.sv
// self-checking bench for the link status transaction handler
`timescale 1ns/1ps

module tb_top;
    logic                  sys_clk, sys_rst, link_cmd, link_active_status;
    logic                  port_is_downstream, port_is_root, root_report_en;
    logic                  slot_cap_init, status_clear, tx_ready;
    logic                  core_req_ready, rx_accept, credit_return, bridge_ur_err;
    logic                  pm_ack, link_down_seen, port_reset, downstream_hot_reset;
    logic [1:0]            slot_pwr_scale;
    logic [7:0]            slot_pwr_value, n_taken;
    logic [3:0]            outstanding;
    lsh_pkg::lsh_pkt_type  core_req, tx_pkt, last_pkt;
    lsh_pkg::lsh_cpl_type  rx_cpl, core_cpl;
    lsh_pkg::lsh_rx_type   rx_pkt;
    int                    n_mismatch, samples_checked, i;

    lsh_txn_handler i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .link_active_status(link_active_status), .port_is_downstream(port_is_downstream),
        .port_is_root(port_is_root), .root_report_en(root_report_en),
        .slot_cap_init(slot_cap_init), .slot_pwr_scale(slot_pwr_scale),
        .slot_pwr_value(slot_pwr_value), .status_clear(status_clear), .core_req(core_req),
        .core_req_ready(core_req_ready), .tx_pkt(tx_pkt), .tx_ready(tx_ready),
        .rx_cpl(rx_cpl), .rx_pkt(rx_pkt), .rx_accept(rx_accept),
        .credit_return(credit_return), .core_cpl(core_cpl), .outstanding(outstanding),
        .bridge_ur_err(bridge_ur_err), .pm_ack(pm_ack), .link_down_seen(link_down_seen),
        .port_reset(port_reset), .downstream_hot_reset(downstream_hot_reset));

    lsh_link_model #(.DLY(2)) i_link (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .link_cmd(link_cmd), .tx_pkt(tx_pkt), .link_active_status(link_active_status),
        .tx_ready(tx_ready), .last_pkt(last_pkt), .n_taken(n_taken));

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // a bound that runs out ends the run
    task automatic timed_out;
        n_mismatch++;
        $display("[FAIL] t=%0t seen=%h expected=%h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic set_link(input logic v);
        @(posedge sys_clk);
        link_cmd <= v;
    endtask

    task automatic send(input lsh_pkg::lsh_kind_type k, input logic [7:0] tag);
        @(posedge sys_clk);
        core_req <= '{valid: 1'b1, kind: k, tag: tag, data: 10'h000};
        @(posedge sys_clk);
        for (i = 0; i < 20 && core_req_ready !== 1'b1; i++)
            @(posedge sys_clk);
        if (i == 20)
            timed_out();
        core_req.valid <= 1'b0;
        #1;
    endtask

    task automatic wait_taken(input logic [7:0] target);
        for (i = 0; i < 30 && n_taken !== target; i++)
            tick();
        if (i == 30)
            timed_out();
    endtask

    task automatic rx_offer(input logic acked, input logic exp);
        @(posedge sys_clk);
        rx_pkt <= '{valid: 1'b1, acked: acked};
        @(posedge sys_clk);
        rx_pkt <= '{valid: 1'b0, acked: 1'b0};
        #1;
        chk(rx_accept, exp);
        chk(credit_return, exp);
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_down_kinds;
        logic [5:0] cplx, errx, pmx;
        cplx = 6'b00_0001;
        errx = 6'b01_0011;
        pmx  = 6'b00_1000;
        for (int k = 0; k < 6; k++)
        begin
            send(lsh_pkg::lsh_kind_type'(k), 8'h10 + 8'(k));
            chk(core_cpl.valid, cplx[k]);
            chk(bridge_ur_err, errx[k]);
            chk(pm_ack, pmx[k]);
            if (cplx[k])
                chk({core_cpl.status, core_cpl.tag}, {lsh_pkg::CPL_ST_UR, 8'h10});
        end
        @(posedge sys_clk);
        port_is_root   <= 1'b1;
        root_report_en <= 1'b0;
        send(lsh_pkg::KIND_NP_REQ, 8'h21);
        chk({core_cpl.valid, bridge_ur_err}, 2'b10);
        @(posedge sys_clk);
        port_is_root <= 1'b0;
        $display("test down_kinds done");
    endtask

    task automatic t_rx;
        rx_offer(1'b0, link_cmd);
        rx_offer(1'b1, 1'b1);
        $display("test rx done");
    endtask

    task automatic t_slot_power;
        logic [7:0] b;
        b = n_taken;
        set_link(1'b1);
        wait_taken(b + 8'h01);
        chk(last_pkt.kind, lsh_pkg::KIND_SLOT_PWR);
        chk(last_pkt.data, {slot_pwr_scale, slot_pwr_value});
        $display("test slot_power done");
    endtask

    task automatic t_np_flush;
        logic [7:0] b;
        b = n_taken;
        send(lsh_pkg::KIND_NP_REQ, 8'h01);
        send(lsh_pkg::KIND_NP_REQ, 8'h02);
        wait_taken(b + 8'h02);
        @(posedge sys_clk);
        rx_cpl <= '{valid: 1'b1, tag: 8'h01, status: 3'h0};
        @(posedge sys_clk);
        rx_cpl.valid <= 1'b0;
        tick();
        chk(outstanding, 4'h4);
        set_link(1'b0);
        for (i = 0; i < 10 && link_down_seen !== 1'b1; i++)
            tick();
        if (i == 10)
            timed_out();
        chk({outstanding, tx_pkt.valid, link_down_seen}, 6'b0000_01);
        @(posedge sys_clk);
        status_clear <= 1'b1;
        @(posedge sys_clk);
        status_clear <= 1'b0;
        tick();
        chk(link_down_seen, 1'b0);
        $display("test np_flush done");
    endtask

    task automatic t_no_cap;
        logic [7:0] b;
        b = n_taken;
        @(posedge sys_clk);
        slot_cap_init <= 1'b0;
        set_link(1'b1);
        repeat (6) tick();
        chk(n_taken, b);
        send(lsh_pkg::KIND_POSTED, 8'h07);
        set_link(1'b0);
        for (i = 0; i < 10 && link_down_seen !== 1'b1; i++)
            tick();
        if (i == 10)
            timed_out();
        chk({n_taken, tx_pkt.valid, bridge_ur_err}, {b, 2'b00});
        @(posedge sys_clk);
        slot_cap_init <= 1'b1;
        $display("test no_cap done");
    endtask

    task automatic t_upstream;
        logic [7:0] b;
        @(posedge sys_clk);
        sys_rst            <= 1'b1;
        port_is_downstream <= 1'b0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        b = 8'h00;
        set_link(1'b1);
        repeat (8) tick();
        chk(n_taken, b);
        set_link(1'b0);
        for (i = 0; i < 10 && port_reset !== 1'b1; i++)
            tick();
        if (i == 10)
            timed_out();
        chk({port_reset, downstream_hot_reset, outstanding}, 6'b11_0000);
        tick();
        chk({port_reset, downstream_hot_reset}, 2'b00);
        send(lsh_pkg::KIND_NP_REQ, 8'h05);
        chk({core_cpl.valid, bridge_ur_err}, 2'b00);
        $display("test upstream done");
    endtask

    // ==========================================================
    // clock and sequence
    // ==========================================================
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        n_mismatch = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        link_cmd = 1'b0;
        port_is_downstream = 1'b1;
        port_is_root = 1'b0;
        root_report_en = 1'b1;
        slot_cap_init = 1'b1;
        slot_pwr_scale = 2'h2;
        slot_pwr_value = 8'h5a;
        status_clear = 1'b0;
        core_req = lsh_pkg::PKT_RST;
        rx_cpl = lsh_pkg::CPL_RST;
        rx_pkt = '{valid: 1'b0, acked: 1'b0};
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_down_kinds();
        t_rx();
        t_slot_power();
        t_rx();
        t_np_flush();
        t_no_cap();
        t_upstream();
        wrap_up();
    end
endmodule
